// ---- design/serial_ctrl_consts.vh ----
// Constants for the serial controller mode and interrupt block
`ifndef SERIAL_CTRL_CONSTS_VH
`define SERIAL_CTRL_CONSTS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_W 16
`define ADDR_SER1_PEND 16'ha808
`define ADDR_SER2_PEND 16'ha80c
`define ADDR_SER1_EN 16'ha848
`define ADDR_SER2_EN 16'ha84c
`define ADDR_SER1_TRIG 16'ha854
`define ADDR_SER2_TRIG 16'ha858
`define ADDR_SER1_FSEL 16'hc854
`define ADDR_SER2_FSEL 16'hc054
`define ADDR_SER1_SPICFG 16'hc858
`define ADDR_SER2_SPICFG 16'hc058
`define ADDR_SER1_FLOW 16'hc868
`define ADDR_SER2_FLOW 16'hc068

// ****************************************
// Field layouts and reset values
// ****************************************
`define IRQ_W 15
`define IRQ_MSB 14
`define TRIG_W 3
`define TRIG_MSB 2
`define FSEL_W 2
`define FSEL_MSB 1
`define SPI_MASTER_BIT 4
`define UART_ERR_MASK 15'h6000
`define PEND_RST 15'h0000
`define EN_RST 15'h0000
`define TRIG_RST 3'h0
`define FSEL_RST 2'h0
`define RDATA_ZERO 32'h0000_0000

// ****************************************
// Function selector codes
// ****************************************
`define FSEL_OFF 2'h0
`define FSEL_UART 2'h1
`define FSEL_SPI 2'h2
`define FSEL_TWI 2'h3

`endif

// ---- design/serial_ctrl_irq.v ----
// Mode selection, second-level interrupt flags and pin routing for two serial controllers
//
// Overview of operation
// - Two independent controllers, each with selector, pending and enable registers.
// - Two-bit selector: 0 off, 1 UART, 2 SPI, 3 TWI.
// - UART only on the first controller; second allows off, SPI, TWI.
// - SPI runs master or slave; TWI runs master only.
// - FIFOs and DMA serve SPI and UART modes, never TWI.
// - Polled operation works without interrupts or DMA.
// - Pending bits 0-4: rx data, tx space, tx idle, rx overrun, tx underrun.
// - Pending bits 5-8: TWI rx done, tx done, command done, NACK.
// - Pending bits 9-12: DMA rx A, rx B, tx A, tx B unloaded.
// - Bit 13 UART frame error, bit 14 parity error, bit 15 unused.
// - Enable bit per pending bit, positions 0-14; both reset to zero.
// - First controller SPI master: B1 MOSI out, B2 MISO in, B3 clock out.
// - First controller SPI slave: B1 MISO out, B2 MOSI, B3 clock, B4 select in.
// - First controller TWI: B1 data, B2 clock, both open-drain.
// - First controller UART: B1 TX out, B2 RX in, B3 CTS, B4 RTS with flow.
// - Rx-data, tx-free, tx-idle sources: trigger 0 edge, 1 level.
`timescale 1ns/10ps
`include "serial_ctrl_consts.vh"

module serial_ctrl_irq (
	input wire ref_clk,
	input wire rst_n,
	input wire [15:0] address,
	input wire read,
	input wire write,
	input wire [3:0] byteenable,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output reg waitrequest,
	input wire [14:0] ser1_events,
	input wire [14:0] ser2_events,
	output reg ser1_irq,
	output reg ser2_irq,
	output reg [1:0] ser1_mode,
	output reg [1:0] ser2_mode,
	output reg ser1_spi_master,
	output reg ser2_spi_master,
	output reg ser1_fifo_dma_en,
	output reg ser2_fifo_dma_en,
	input wire ser1_tx_data,
	input wire ser1_clk_out,
	input wire ser1_sda_low,
	input wire ser1_scl_low,
	input wire ser1_rts_n,
	output reg ser1_rx_data,
	output reg ser1_clk_in,
	output reg ser1_select_in_n,
	output reg ser1_cts_n,
	output reg ser1_sda_in,
	output reg ser1_scl_in,
	input wire ser2_tx_data,
	input wire ser2_clk_out,
	input wire ser2_sda_low,
	input wire ser2_scl_low,
	output reg ser2_rx_data,
	output reg ser2_clk_in,
	output reg ser2_select_in_n,
	output reg ser2_sda_in,
	output reg ser2_scl_in,
	input wire [4:1] port_b_in,
	output reg [4:1] port_b_out,
	output reg [4:1] port_b_oe,
	input wire [3:0] port_a_in,
	output reg [3:0] port_a_out,
	output reg [3:0] port_a_oe
);

	// ****************************************
	// Helper functions
	// ****************************************
	function [31:0] lane_mask;
		input [3:0] be;
		begin
			lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		end
	endfunction
	// Sticky flags: set wins over a clear in the same cycle
	function [14:0] pend_next;
		input [14:0] pend;
		input [14:0] ev;
		input [14:0] ev_prev;
		input [2:0] trig;
		input [14:0] clr;
		reg [2:0] low_set;
		begin
			low_set = ev[`TRIG_MSB:0] & (trig | ~ev_prev[`TRIG_MSB:0]);
			pend_next = (pend & ~clr) | {ev[`IRQ_MSB:`TRIG_W], low_set};
		end
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	reg [14:0] ser1_pend_r, ser2_pend_r;
	reg [14:0] ser1_en_r, ser2_en_r;
	reg [2:0] ser1_trig_r, ser2_trig_r;
	reg [1:0] ser1_fsel_r, ser2_fsel_r;
	reg ser1_master_r, ser2_master_r;
	reg ser1_flow_r, ser2_flow_r;
	reg [14:0] ser1_ev_prev_r, ser2_ev_prev_r;
	reg [4:1] pb_meta_r, pb_sync_r;
	reg [3:0] pa_meta_r, pa_sync_r;
	wire [31:0] wmask = lane_mask(byteenable);
	wire [31:0] wdata_m = writedata & wmask;
	wire bus_req = read | write;
	wire wr_take = write & ~waitrequest;
	wire [14:0] ser2_ev_m = ser2_events & ~`UART_ERR_MASK;
	wire [14:0] ser1_clr = (wr_take && address == `ADDR_SER1_PEND) ? wdata_m[`IRQ_MSB:0] : `PEND_RST;
	wire [14:0] ser2_clr = (wr_take && address == `ADDR_SER2_PEND) ? wdata_m[`IRQ_MSB:0] : `PEND_RST;
	reg [31:0] rdata_nxt;

	// ****************************************
	// Avalon-MM slave: one wait state per access
	// ****************************************
	always @* begin
		rdata_nxt = `RDATA_ZERO;
		case (address)
			`ADDR_SER1_PEND: rdata_nxt[`IRQ_MSB:0] = ser1_pend_r;
			`ADDR_SER2_PEND: rdata_nxt[`IRQ_MSB:0] = ser2_pend_r;
			`ADDR_SER1_EN: rdata_nxt[`IRQ_MSB:0] = ser1_en_r;
			`ADDR_SER2_EN: rdata_nxt[`IRQ_MSB:0] = ser2_en_r;
			`ADDR_SER1_TRIG: rdata_nxt[`TRIG_MSB:0] = ser1_trig_r;
			`ADDR_SER2_TRIG: rdata_nxt[`TRIG_MSB:0] = ser2_trig_r;
			`ADDR_SER1_FSEL: rdata_nxt[`FSEL_MSB:0] = ser1_fsel_r;
			`ADDR_SER2_FSEL: rdata_nxt[`FSEL_MSB:0] = ser2_fsel_r;
			`ADDR_SER1_SPICFG: rdata_nxt[`SPI_MASTER_BIT] = ser1_master_r;
			`ADDR_SER2_SPICFG: rdata_nxt[`SPI_MASTER_BIT] = ser2_master_r;
			`ADDR_SER1_FLOW: rdata_nxt[0] = ser1_flow_r;
			`ADDR_SER2_FLOW: rdata_nxt[0] = ser2_flow_r;
			default: rdata_nxt = `RDATA_ZERO;
		endcase
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			waitrequest <= 1'b1;
			readdata <= `RDATA_ZERO;
		end else if (bus_req && waitrequest) begin
			waitrequest <= 1'b0;
			readdata <= read ? rdata_nxt : `RDATA_ZERO;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			ser1_en_r <= `EN_RST;
			ser2_en_r <= `EN_RST;
			ser1_trig_r <= `TRIG_RST;
			ser2_trig_r <= `TRIG_RST;
			ser1_fsel_r <= `FSEL_RST;
			ser2_fsel_r <= `FSEL_RST;
			ser1_master_r <= 1'b0;
			ser2_master_r <= 1'b0;
			ser1_flow_r <= 1'b0;
			ser2_flow_r <= 1'b0;
		end else if (wr_take) begin
			case (address)
				`ADDR_SER1_EN: ser1_en_r <= (ser1_en_r & ~wmask[`IRQ_MSB:0]) | wdata_m[`IRQ_MSB:0];
				`ADDR_SER2_EN: ser2_en_r <= (ser2_en_r & ~wmask[`IRQ_MSB:0]) | wdata_m[`IRQ_MSB:0];
				`ADDR_SER1_TRIG: if (byteenable[0]) ser1_trig_r <= writedata[`TRIG_MSB:0];
				`ADDR_SER2_TRIG: if (byteenable[0]) ser2_trig_r <= writedata[`TRIG_MSB:0];
				`ADDR_SER1_FSEL: if (byteenable[0]) ser1_fsel_r <= writedata[`FSEL_MSB:0];
				`ADDR_SER2_FSEL: if (byteenable[0] && writedata[`FSEL_MSB:0] != `FSEL_UART)
					ser2_fsel_r <= writedata[`FSEL_MSB:0];
				`ADDR_SER1_SPICFG: if (byteenable[0]) ser1_master_r <= writedata[`SPI_MASTER_BIT];
				`ADDR_SER2_SPICFG: if (byteenable[0]) ser2_master_r <= writedata[`SPI_MASTER_BIT];
				`ADDR_SER1_FLOW: if (byteenable[0]) ser1_flow_r <= writedata[0];
				`ADDR_SER2_FLOW: if (byteenable[0]) ser2_flow_r <= writedata[0];
				default: ser1_flow_r <= ser1_flow_r;
			endcase
		end
	end

	// ****************************************
	// Pending flags and interrupt requests
	// ****************************************
	// Interrupts are optional: flags are readable for polled use
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			ser1_pend_r <= `PEND_RST;
			ser2_pend_r <= `PEND_RST;
			ser1_ev_prev_r <= `PEND_RST;
			ser2_ev_prev_r <= `PEND_RST;
			ser1_irq <= 1'b0;
			ser2_irq <= 1'b0;
		end else begin
			ser1_ev_prev_r <= ser1_events;
			ser2_ev_prev_r <= ser2_ev_m;
			ser1_pend_r <= pend_next(ser1_pend_r, ser1_events, ser1_ev_prev_r, ser1_trig_r, ser1_clr);
			ser2_pend_r <= pend_next(ser2_pend_r, ser2_ev_m, ser2_ev_prev_r, ser2_trig_r, ser2_clr);
			ser1_irq <= |(ser1_pend_r & ser1_en_r);
			ser2_irq <= |(ser2_pend_r & ser2_en_r);
		end
	end

	// ****************************************
	// Mode outputs
	// ****************************************
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			ser1_mode <= `FSEL_RST;
			ser2_mode <= `FSEL_RST;
			ser1_spi_master <= 1'b0;
			ser2_spi_master <= 1'b0;
			ser1_fifo_dma_en <= 1'b0;
			ser2_fifo_dma_en <= 1'b0;
		end else begin
			ser1_mode <= ser1_fsel_r;
			ser2_mode <= ser2_fsel_r;
			ser1_spi_master <= ser1_master_r;
			ser2_spi_master <= ser2_master_r;
			ser1_fifo_dma_en <= (ser1_fsel_r == `FSEL_SPI) || (ser1_fsel_r == `FSEL_UART);
			ser2_fifo_dma_en <= (ser2_fsel_r == `FSEL_SPI);
		end
	end

	// ****************************************
	// Pin input synchronisers
	// ****************************************
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			pb_meta_r <= 4'hf;
			pb_sync_r <= 4'hf;
			pa_meta_r <= 4'hf;
			pa_sync_r <= 4'hf;
		end else begin
			pb_meta_r <= port_b_in;
			pb_sync_r <= pb_meta_r;
			pa_meta_r <= port_a_in;
			pa_sync_r <= pa_meta_r;
		end
	end

	// ****************************************
	// Pin routing, first controller on port B
	// ****************************************
	reg [4:1] pb_out_nxt, pb_oe_nxt;
	reg s1_rx_nxt, s1_clk_nxt, s1_sel_nxt, s1_cts_nxt, s1_sda_nxt, s1_scl_nxt;
	always @* begin
		pb_out_nxt = 4'h0;
		pb_oe_nxt = 4'h0;
		s1_rx_nxt = 1'b1;
		s1_clk_nxt = 1'b0;
		s1_sel_nxt = 1'b1;
		s1_cts_nxt = 1'b0;
		s1_sda_nxt = 1'b1;
		s1_scl_nxt = 1'b1;
		case (ser1_fsel_r)
			`FSEL_SPI: begin
				pb_out_nxt[1] = ser1_tx_data;
				pb_oe_nxt[1] = 1'b1;
				s1_rx_nxt = pb_sync_r[2];
				if (ser1_master_r) begin
					pb_out_nxt[3] = ser1_clk_out;
					pb_oe_nxt[3] = 1'b1;
				end else begin
					s1_clk_nxt = pb_sync_r[3];
					s1_sel_nxt = pb_sync_r[4];
				end
			end
			`FSEL_TWI: begin
				pb_oe_nxt[1] = ser1_sda_low;
				pb_oe_nxt[2] = ser1_scl_low;
				s1_sda_nxt = pb_sync_r[1];
				s1_scl_nxt = pb_sync_r[2];
			end
			`FSEL_UART: begin
				pb_out_nxt[1] = ser1_tx_data;
				pb_oe_nxt[1] = 1'b1;
				s1_rx_nxt = pb_sync_r[2];
				if (ser1_flow_r) begin
					s1_cts_nxt = pb_sync_r[3];
					pb_out_nxt[4] = ser1_rts_n;
					pb_oe_nxt[4] = 1'b1;
				end
			end
			default: pb_oe_nxt = 4'h0;
		endcase
	end

	// ****************************************
	// Pin routing, second controller on port A
	// ****************************************
	reg [3:0] pa_out_nxt, pa_oe_nxt;
	reg s2_rx_nxt, s2_clk_nxt, s2_sel_nxt, s2_sda_nxt, s2_scl_nxt;
	always @* begin
		pa_out_nxt = 4'h0;
		pa_oe_nxt = 4'h0;
		s2_rx_nxt = 1'b1;
		s2_clk_nxt = 1'b0;
		s2_sel_nxt = 1'b1;
		s2_sda_nxt = 1'b1;
		s2_scl_nxt = 1'b1;
		case (ser2_fsel_r)
			`FSEL_SPI: begin
				pa_out_nxt[0] = ser2_tx_data;
				pa_oe_nxt[0] = 1'b1;
				s2_rx_nxt = pa_sync_r[1];
				if (ser2_master_r) begin
					pa_out_nxt[2] = ser2_clk_out;
					pa_oe_nxt[2] = 1'b1;
				end else begin
					s2_clk_nxt = pa_sync_r[2];
					s2_sel_nxt = pa_sync_r[3];
				end
			end
			`FSEL_TWI: begin
				pa_oe_nxt[1] = ser2_sda_low;
				pa_oe_nxt[2] = ser2_scl_low;
				s2_sda_nxt = pa_sync_r[1];
				s2_scl_nxt = pa_sync_r[2];
			end
			default: pa_oe_nxt = 4'h0;
		endcase
	end

	// ****************************************
	// Registered pin and engine outputs
	// ****************************************
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			port_b_out <= 4'h0;
			port_b_oe <= 4'h0;
			port_a_out <= 4'h0;
			port_a_oe <= 4'h0;
			ser1_rx_data <= 1'b1;
			ser1_clk_in <= 1'b0;
			ser1_select_in_n <= 1'b1;
			ser1_cts_n <= 1'b0;
			ser1_sda_in <= 1'b1;
			ser1_scl_in <= 1'b1;
			ser2_rx_data <= 1'b1;
			ser2_clk_in <= 1'b0;
			ser2_select_in_n <= 1'b1;
			ser2_sda_in <= 1'b1;
			ser2_scl_in <= 1'b1;
		end else begin
			port_b_out <= pb_out_nxt;
			port_b_oe <= pb_oe_nxt;
			port_a_out <= pa_out_nxt;
			port_a_oe <= pa_oe_nxt;
			ser1_rx_data <= s1_rx_nxt;
			ser1_clk_in <= s1_clk_nxt;
			ser1_select_in_n <= s1_sel_nxt;
			ser1_cts_n <= s1_cts_nxt;
			ser1_sda_in <= s1_sda_nxt;
			ser1_scl_in <= s1_scl_nxt;
			ser2_rx_data <= s2_rx_nxt;
			ser2_clk_in <= s2_clk_nxt;
			ser2_select_in_n <= s2_sel_nxt;
			ser2_sda_in <= s2_sda_nxt;
			ser2_scl_in <= s2_scl_nxt;
		end
	end

endmodule

// ---- tb/serial_ctrl_irq_checker.sv ----
// Assertion checker for the serial controller mode and interrupt block
`timescale 1ns/10ps
`include "serial_ctrl_consts.vh"
module serial_ctrl_irq_checker (
	input wire ref_clk,
	input wire rst_n,
	input wire [15:0] address,
	input wire read,
	input wire write,
	input wire waitrequest,
	input wire [1:0] ser1_mode,
	input wire [1:0] ser2_mode,
	input wire ser1_spi_master,
	input wire ser1_fifo_dma_en,
	input wire ser2_fifo_dma_en,
	input wire ser1_clk_out,
	input wire ser1_sda_low,
	input wire ser2_sda_low,
	input wire [4:1] port_b_out,
	input wire [4:1] port_b_oe,
	input wire [3:0] port_a_out,
	input wire [3:0] port_a_oe
);
// ****************************************
// Properties
// ****************************************
wire fsel1_wr = write && !waitrequest && address == `ADDR_SER1_FSEL;
default clocking dc @(posedge ref_clk); endclocking
default disable iff (!rst_n);
property p_one_wait; (read || write) && waitrequest |=> !waitrequest ##1 waitrequest; endproperty
property p_mode_cause; $changed(ser1_mode) |-> $past(fsel1_wr, 2); endproperty
property p_no_uart2; ser2_mode != `FSEL_UART; endproperty
property p_fifo1; ser1_fifo_dma_en == (ser1_mode == `FSEL_SPI || ser1_mode == `FSEL_UART); endproperty
property p_fifo2; ser2_fifo_dma_en == (ser2_mode == `FSEL_SPI); endproperty
property p_off_quiet; ser1_mode == `FSEL_OFF && $stable(ser1_mode) |-> port_b_oe == 4'h0; endproperty
property p_twi1; ser1_mode == `FSEL_TWI && $stable(ser1_mode)
	|-> port_b_out[2:1] == 2'h0 && port_b_oe[4:3] == 2'h0 && port_b_oe[1] == $past(ser1_sda_low); endproperty
property p_twi2; ser2_mode == `FSEL_TWI && $stable(ser2_mode) |-> port_a_out[2:1] == 2'h0
	&& port_a_oe[0] == 1'b0 && port_a_oe[3] == 1'b0 && port_a_oe[1] == $past(ser2_sda_low); endproperty
property p_spi_mst; ser1_mode == `FSEL_SPI && ser1_spi_master && $stable(ser1_mode) && $stable(ser1_spi_master)
	|-> port_b_oe == 4'h5 && port_b_out[3] == $past(ser1_clk_out); endproperty
a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait state");
a_mode_cause: assert property (p_mode_cause) else $error("mode changed without selector write");
a_no_uart2: assert property (p_no_uart2) else $error("second controller in UART mode");
a_fifo1: assert property (p_fifo1) else $error("first fifo enable wrong for mode");
a_fifo2: assert property (p_fifo2) else $error("second fifo enable wrong for mode");
a_off_quiet: assert property (p_off_quiet) else $error("pins driven while disabled");
a_twi1: assert property (p_twi1) else $error("first two-wire pins not open-drain");
a_twi2: assert property (p_twi2) else $error("second two-wire pins not open-drain");
a_spi_mst: assert property (p_spi_mst) else $error("master pin directions wrong");
c_twi1: cover property (ser1_mode == `FSEL_TWI);
c_twi2: cover property (ser2_mode == `FSEL_TWI);
c_spi_mst: cover property (ser1_mode == `FSEL_SPI && ser1_spi_master);
c_spi2_mst: cover property (ser2_mode == `FSEL_SPI && port_a_oe == 4'h5);
endmodule
bind serial_ctrl_irq serial_ctrl_irq_checker chk_u (.ref_clk, .rst_n, .address, .read, .write, .waitrequest,
	.ser1_mode, .ser2_mode, .ser1_spi_master, .ser1_fifo_dma_en, .ser2_fifo_dma_en, .ser1_clk_out, .ser1_sda_low,
	.ser2_sda_low, .port_b_out, .port_b_oe, .port_a_out, .port_a_oe);

// ---- tb/serial_pin_partner.sv ----
// External devices on the port pins, with pull-ups on every line
`timescale 1ns/10ps
module serial_pin_partner (
	input wire [4:1] port_b_out,
	input wire [4:1] port_b_oe,
	input wire [4:1] b_drive,
	input wire [4:1] b_drive_en,
	input wire [3:0] port_a_out,
	input wire [3:0] port_a_oe,
	input wire [3:0] a_drive,
	input wire [3:0] a_drive_en,
	output wire [4:1] port_b_in,
	output wire [3:0] port_a_in
);
// Released lines float up; any party pulling low wins
assign port_b_in = (~port_b_oe | port_b_out) & (~b_drive_en | b_drive);
assign port_a_in = (~port_a_oe | port_a_out) & (~a_drive_en | a_drive);
endmodule

// ---- tb/tb_top.sv ----
// Self-checking testbench for the serial controller mode and interrupt block
`timescale 1ns/10ps
`include "serial_ctrl_consts.vh"
module tb_top;
logic ref_clk = 0, rst_n = 0, read = 0, write = 0, waitrequest, ser1_irq, ser2_irq;
logic [15:0] address = 16'h0000, pa;
logic [3:0] byteenable = 4'hf;
logic [31:0] writedata = 32'h0, readdata, e;
logic [14:0] ser1_events = 15'h0, ser2_events = 15'h0;
logic [1:0] ser1_mode, ser2_mode;
logic ser1_spi_master, ser2_spi_master, ser1_fifo_dma_en, ser2_fifo_dma_en;
logic ser1_tx_data = 0, ser1_clk_out = 0, ser1_sda_low = 0, ser1_scl_low = 0, ser1_rts_n = 1;
logic ser2_tx_data = 0, ser2_clk_out = 0, ser2_sda_low = 0, ser2_scl_low = 0;
logic ser1_rx_data, ser1_clk_in, ser1_select_in_n, ser1_cts_n, ser1_sda_in, ser1_scl_in;
logic ser2_rx_data, ser2_clk_in, ser2_select_in_n, ser2_sda_in, ser2_scl_in;
logic [4:1] port_b_in, port_b_out, port_b_oe, b_drive = 4'hf, b_drive_en = 4'h0;
logic [3:0] port_a_in, port_a_out, port_a_oe, a_drive = 4'hf, a_drive_en = 4'h0;
logic [15:0] regs [8] = '{`ADDR_SER1_PEND, `ADDR_SER2_PEND, `ADDR_SER1_EN, `ADDR_SER2_EN,
	`ADDR_SER1_TRIG, `ADDR_SER2_TRIG, `ADDR_SER1_FSEL, `ADDR_SER2_FSEL};
int mismatches = 0, checked = 0, i;

always #2 ref_clk = ~ref_clk;

serial_ctrl_irq dut_u (.ref_clk, .rst_n, .address, .read, .write, .byteenable, .writedata, .readdata,
	.waitrequest, .ser1_events, .ser2_events, .ser1_irq, .ser2_irq, .ser1_mode, .ser2_mode, .ser1_spi_master,
	.ser2_spi_master, .ser1_fifo_dma_en, .ser2_fifo_dma_en, .ser1_tx_data, .ser1_clk_out, .ser1_sda_low,
	.ser1_scl_low, .ser1_rts_n, .ser1_rx_data, .ser1_clk_in, .ser1_select_in_n, .ser1_cts_n, .ser1_sda_in,
	.ser1_scl_in, .ser2_tx_data, .ser2_clk_out, .ser2_sda_low, .ser2_scl_low, .ser2_rx_data, .ser2_clk_in,
	.ser2_select_in_n, .ser2_sda_in, .ser2_scl_in, .port_b_in, .port_b_out, .port_b_oe, .port_a_in,
	.port_a_out, .port_a_oe);
serial_pin_partner pin_u (.port_b_out, .port_b_oe, .b_drive, .b_drive_en, .port_a_out, .port_a_oe,
	.a_drive, .a_drive_en, .port_b_in, .port_a_in);

// ****************************************
// Bus and check tasks
// ****************************************
task stop_test;
	if (mismatches == 0 && checked > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
	checked++;
	if (got !== exp) begin
		$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		mismatches++;
	end
endtask
task ticks(input int n);
	repeat (n) @(posedge ref_clk);
endtask
// Holds the request until waitrequest is sampled low, then releases it
task bus(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
	int n;
	n = 0;
	read <= !wr;
	write <= wr;
	address <= a;
	writedata <= d;
	do begin
		@(posedge ref_clk);
		n++;
	end while (waitrequest !== 1'b0 && n < 20);
	q = readdata;
	if (n >= 20) begin
		mismatches++;
		stop_test;
	end
	read <= 1'b0;
	write <= 1'b0;
	@(posedge ref_clk);
endtask
task wr(input logic [15:0] a, input logic [31:0] d);
	logic [31:0] q;
	bus(1'b1, a, d, q);
endtask
task rd(input logic [15:0] a, input logic [31:0] x);
	logic [31:0] q;
	bus(1'b0, a, 32'h0, q);
	chk(q, x);
endtask
// Mode-specific setup first, selector last
task pins(input logic [31:0] f, input logic [31:0] s, input logic [31:0] u, input logic [4:1] oe);
	wr(`ADDR_SER1_SPICFG, s);
	wr(`ADDR_SER1_FLOW, u);
	wr(`ADDR_SER1_FSEL, f);
	ticks(4);
	chk(32'(port_b_oe), 32'(oe));
endtask

// ****************************************
// Main sequence
// ****************************************
initial begin
	ticks(12);
	rst_n <= 1'b1;
	ticks(1);
	for (i = 0; i < 8; i++) rd(regs[i], 32'h0);
	wr(16'h1000, 32'hffff_ffff);
	rd(16'h1000, 32'h0);
	wr(`ADDR_SER1_EN, 32'hffff_ffff);
	rd(`ADDR_SER1_EN, 32'h0000_7fff);
	wr(`ADDR_SER1_EN, 32'h0);
	for (i = 0; i < 30; i++) begin
		pa = (i < 15) ? `ADDR_SER1_PEND : `ADDR_SER2_PEND;
		e = (i >= 28) ? 32'h0 : 32'h1 << (i % 15);
		if (i < 15) ser1_events[i] <= 1'b1;
		else ser2_events[i - 15] <= 1'b1;
		ticks(1);
		ser1_events <= 15'h0;
		ser2_events <= 15'h0;
		ticks(1);
		rd(pa, e);
		wr(pa, 32'h0);
		rd(pa, e);
		wr(pa, e);
		rd(pa, 32'h0);
	end
	ser1_events <= 15'h1;
	ticks(2);
	wr(`ADDR_SER1_PEND, 32'h1);
	rd(`ADDR_SER1_PEND, 32'h0);
	wr(`ADDR_SER1_TRIG, 32'h1);
	wr(`ADDR_SER1_PEND, 32'h1);
	rd(`ADDR_SER1_PEND, 32'h1);
	ser1_events <= 15'h10;
	wr(`ADDR_SER1_EN, 32'h20);
	wr(`ADDR_SER1_PEND, 32'h1);
	ticks(2);
	chk(32'(ser1_irq), 32'h0);
	ser1_events <= 15'h20;
	ticks(1);
	ser1_events <= 15'h0;
	ticks(3);
	chk(32'(ser1_irq), 32'h1);
	wr(`ADDR_SER1_PEND, 32'h30);
	ticks(2);
	chk(32'(ser1_irq), 32'h0);
	wr(`ADDR_SER2_EN, 32'h100);
	ser2_events <= 15'h100;
	ticks(1);
	ser2_events <= 15'h0;
	ticks(3);
	chk(32'(ser2_irq), 32'h1);
	ser1_events <= 15'h6;
	wr(`ADDR_SER1_TRIG, 32'h4);
	wr(`ADDR_SER1_PEND, 32'h6);
	rd(`ADDR_SER1_PEND, 32'h4);
	ser1_events <= 15'h0;
	byteenable <= 4'h2;
	wr(`ADDR_SER1_EN, 32'hffff_ffff);
	byteenable <= 4'hf;
	rd(`ADDR_SER1_EN, 32'h0000_7f20);
	for (i = 0; i < 4; i++) begin
		wr(`ADDR_SER1_FSEL, i);
		rd(`ADDR_SER1_FSEL, i);
		ticks(2);
		chk(32'(ser1_mode), i);
	end
	wr(`ADDR_SER2_FSEL, 32'h2);
	wr(`ADDR_SER2_FSEL, 32'h1);
	rd(`ADDR_SER2_FSEL, 32'h2);
	ser1_tx_data <= 1'b1;
	ser1_clk_out <= 1'b1;
	b_drive <= 4'h0;
	b_drive_en <= 4'h2;
	pins(2, 32'h10, 0, 4'h5);
	chk(32'({port_b_out[3], port_b_out[1], ser1_rx_data}), 32'h6);
	chk(32'({ser1_spi_master, ser1_fifo_dma_en, ser1_mode}), 32'he);
	b_drive <= 4'h4;
	b_drive_en <= 4'he;
	pins(2, 0, 0, 4'h1);
	chk(32'({ser1_select_in_n, ser1_clk_in, ser1_rx_data}), 32'h2);
	ser1_sda_low <= 1'b1;
	ser1_scl_low <= 1'b1;
	b_drive <= 4'h0;
	b_drive_en <= 4'h2;
	pins(3, 0, 0, 4'h3);
	chk(32'({port_b_out, ser1_sda_in, ser1_scl_in}), 32'h0);
	ser1_rts_n <= 1'b0;
	b_drive_en <= 4'h4;
	pins(1, 0, 1, 4'h9);
	chk(32'({port_b_out[4], port_b_out[1], ser1_cts_n}), 32'h2);
	pins(1, 0, 0, 4'h1);
	ser2_tx_data <= 1'b1;
	ser2_clk_out <= 1'b1;
	a_drive <= 4'h0;
	a_drive_en <= 4'ha;
	ticks(4);
	chk(32'({port_a_oe, port_a_out, ser2_rx_data, ser2_clk_in, ser2_select_in_n}), 32'h08a);
	wr(`ADDR_SER2_FSEL, 32'h0);
	wr(`ADDR_SER2_SPICFG, 32'h10);
	wr(`ADDR_SER2_FSEL, 32'h2);
	ticks(2);
	chk(32'({port_a_oe, port_a_out, ser2_spi_master, ser2_fifo_dma_en, ser2_mode}), 32'h55e);
	ser2_sda_low <= 1'b1;
	a_drive_en <= 4'h0;
	wr(`ADDR_SER2_FSEL, 32'h3);
	ticks(4);
	chk(32'({port_a_oe, port_a_out, ser2_sda_in, ser2_scl_in}), 32'h081);
	ser2_sda_low <= 1'b0;
	ser2_scl_low <= 1'b1;
	ticks(5);
	chk(32'({port_a_oe, port_a_out, ser2_sda_in, ser2_scl_in}), 32'h102);
	pins(0, 0, 0, 4'h0);
	// Reset in mid-run must bring the pending, enable, trigger and selector registers back to zero
	rst_n <= 1'b0;
	ticks(3);
	rst_n <= 1'b1;
	ticks(1);
	for (i = 0; i < 8; i++) rd(regs[i], 32'h0);
	chk(32'({ser2_irq, ser2_mode, port_a_oe}), 32'h0);
	stop_test;
end
endmodule
